// ---- core/msd_core.sv ----
// Purpose: Command decode, mode program and burst timing of a four-bank
//          mobile SDRAM, seen from inside the memory.
// Assumes: Controller keeps all spacing and refresh duties.
// Notes:   Array storage is a small flip-flop model addressed by bank/col.
// Overview of operation
// - Sample all inputs except arst_n on rising clock edge
// - Read latency selectable as 1, 2 or 3
// - Burst length 1,2,4,8 or full page
// - Sequential or interleaved column order
// - Burst reads with single-word writes mode
// - New column command accepted every clock
// - Cut read drives 2,1,0 more words
// - Deep power down optional, enabled per part
// - Mask blocks writes now, reads after two
// - Address bit 9 enables single-word writes
`timescale 1ns/10ps
`default_nettype none

module msd_core
	import msd_pkg::*;
#(
	parameter int  MEM_COLS       = 16,
	parameter bit  DEEP_PD_ENABLE = 1'b0
)
(
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              clockEnable,
	input  wire logic              chipSelect_n,
	input  wire logic              rowStrobe_n,
	input  wire logic              colStrobe_n,
	input  wire logic              writeEnable_n,
	input  wire logic [BANK_W-1:0] bank,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              lower_byte_mask,
	input  wire logic              upper_byte_mask,
	input  wire logic [DATA_W-1:0] dataIn,
	output logic      [DATA_W-1:0] dataOut,
	output logic      [1:0]        dataOutEnable,
	output logic      [2:0]        readLatency,
	output logic                   deep_power_down
);
	import msd_pkg::*;

	localparam int MEM_AW = $clog2(MEM_COLS);

	// -----------------------------------------------------------------
	// Command decode
	// -----------------------------------------------------------------
	msd_cmd_t cmd;
	logic     cmdValid;

	always_comb
	begin
		cmd      = msd_cmd_t'({rowStrobe_n, colStrobe_n, writeEnable_n});
		cmdValid = !chipSelect_n && clockEnable;
	end

	// -----------------------------------------------------------------
	// Mode register
	// -----------------------------------------------------------------
	logic [2:0] burstCode;
	logic       interleave;
	logic       singleWrite;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			burstCode   <= BL_RESET;
			interleave  <= BT_RESET;
			singleWrite <= 1'b0;
			readLatency <= CL_RESET;
		end
		else if (cmdValid && cmd == CMD_MODE && bank == MODE_SEL_NORMAL)
		begin
			burstCode   <= addr[BL_LSB +: 3];
			interleave  <= addr[BT_BIT];
			singleWrite <= addr[WBL_BIT];
			readLatency <= addr[CL_LSB +: 3];
		end
	end

	// Optional deep power down: entry is a stop code with clock enable low
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			deep_power_down <= 1'b0;
		else if (!DEEP_PD_ENABLE)
			deep_power_down <= 1'b0;
		else if (!chipSelect_n && !clockEnable && cmd == CMD_STOP)
			deep_power_down <= 1'b1;
		else if (clockEnable)
			deep_power_down <= 1'b0;
	end

	// -----------------------------------------------------------------
	// Burst tracking
	// -----------------------------------------------------------------
	logic [COL_W-1:0]  wrapMask;
	logic [COL_W:0]    burstLen;
	logic              burstActive;
	logic              burstWrite;
	logic [COL_W-1:0]  startCol;
	logic [BANK_W-1:0] burstBank;
	logic [COL_W:0]    beat;
	logic [COL_W-1:0]  curCol;

	always_comb
	begin
		case (burstCode)
			BL_CODE_1:    wrapMask = 9'h000;
			BL_CODE_2:    wrapMask = 9'h001;
			BL_CODE_4:    wrapMask = 9'h003;
			BL_CODE_8:    wrapMask = 9'h007;
			BL_CODE_PAGE: wrapMask = 9'h1ff;
			default:      wrapMask = 9'h000;
		endcase
		burstLen = {1'b0, wrapMask} + 10'h001;
	end

	msd_burst_seq u_seq
	(
		.startCol   (startCol),
		.step       (beat[COL_W-1:0]),
		.wrapMask   (wrapMask),
		.interleave (interleave),
		.column     (curCol)
	);

	logic isCol;
	logic isCut;
	logic lastBeat;

	always_comb
	begin
		isCol    = cmdValid && (cmd == CMD_READ || cmd == CMD_WRITE);
		isCut    = cmdValid && (cmd == CMD_PRECHARGE || cmd == CMD_STOP);
		lastBeat = (beat + 10'h001 >= burstLen) && burstCode != BL_CODE_PAGE;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			burstActive <= 1'b0;
			burstWrite  <= 1'b0;
			startCol    <= '0;
			burstBank   <= '0;
			beat        <= '0;
		end
		else if (isCol)
		begin
			burstActive <= !(cmd == CMD_WRITE && (singleWrite || burstCode == BL_CODE_1))
				&& burstCode != BL_CODE_1;
			burstWrite  <= (cmd == CMD_WRITE);
			startCol    <= addr[COL_W-1:0];
			burstBank   <= bank;
			beat        <= 10'h001;
		end
		else if (isCut || (burstActive && lastBeat))
			burstActive <= 1'b0;
		else if (burstActive)
			beat <= beat + 10'h001;
	end

	// -----------------------------------------------------------------
	// Storage model
	// -----------------------------------------------------------------
	logic [DATA_W-1:0] memWord;
	logic              wrNow;
	logic              rdNow;
	logic [COL_W-1:0]  accCol;
	logic [BANK_W-1:0] accBank;
	logic [MEM_AW+1:0] memIdx;

	always_comb
	begin
		wrNow   = (isCol && cmd == CMD_WRITE) || (burstActive && burstWrite && !isCol);
		rdNow   = (isCol && cmd == CMD_READ) || (burstActive && !burstWrite && !isCol && !isCut);
		accCol  = isCol ? addr[COL_W-1:0] : curCol;
		accBank = isCol ? bank : burstBank;
		memIdx  = {accBank, accCol[MEM_AW-1:0]};
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_lane
			// Each lane owns its storage so that one process writes each array
			logic       laneMask;
			logic [7:0] laneMem [4*MEM_COLS];
			assign laneMask = (g == 0) ? lower_byte_mask : upper_byte_mask;
			assign memWord[8*g +: 8] = laneMem[memIdx];
			always_ff @(posedge clock)
			begin
				if (wrNow && !laneMask)
					laneMem[memIdx] <= dataIn[8*g +: 8];
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Read latency pipeline and read masking
	// -----------------------------------------------------------------
	logic [DATA_W-1:0] rdData  [2];
	logic [1:0]        rdValid;
	logic [1:0]        maskPipe [READ_MASK_LAT-1];

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdValid <= '0;
			for (int i = 0; i < 2; i++)
				rdData[i] <= '0;
			for (int i = 0; i < READ_MASK_LAT - 1; i++)
				maskPipe[i] <= '0;
		end
		else
		begin
			rdValid     <= {rdValid[0], rdNow};
			rdData[0]   <= memWord;
			rdData[1]   <= rdData[0];
			maskPipe[0] <= {upper_byte_mask, lower_byte_mask};
			for (int i = 1; i < READ_MASK_LAT - 1; i++)
				maskPipe[i] <= maskPipe[i - 1];
		end
	end

	logic [1:0]        selIdx;
	logic              validTap;
	logic [DATA_W-1:0] dataTap;

	// Latency one reads the array directly; latency two takes one pipe stage, latency three takes two
	always_comb
	begin
		selIdx = (readLatency == 3'h1) ? 2'h0 : ((readLatency == 3'h2) ? 2'h1 : 2'h2);
		if (selIdx == 2'h0)
		begin
			validTap = rdNow;
			dataTap  = memWord;
		end
		else
		begin
			validTap = rdValid[selIdx[1]];
			dataTap  = rdData[selIdx[1]];
		end
	end

	// The output register adds the last clock of read latency
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			dataOut <= '0;
		else
			dataOut <= dataTap;
	end

	// The output register gives one clock of mask delay, the mask pipe the rest
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			dataOutEnable <= 2'h0;
		else
			dataOutEnable <= {2{validTap}} & ~maskPipe[READ_MASK_LAT - 2];
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_cs_gates_mode: assert property (@(posedge clock) disable iff (!arst_n)
		chipSelect_n |=> $stable(burstCode))
		else $error("Mode changed without chip select");
	a_mode_latency: assert property (@(posedge clock) disable iff (!arst_n)
		(cmdValid && cmd == CMD_MODE && bank == MODE_SEL_NORMAL)
		|=> readLatency == $past(addr[CL_LSB +: 3]))
		else $error("Read latency not taken from address");
	a_single_write: assert property (@(posedge clock) disable iff (!arst_n)
		(isCol && cmd == CMD_WRITE && singleWrite) |=> !burstActive)
		else $error("Write burst in single-word mode");
	a_cut_burst: assert property (@(posedge clock) disable iff (!arst_n)
		(isCut && !isCol) |=> !burstActive)
		else $error("Burst not stopped by cut");
	a_read_lat3: assert property (@(posedge clock) disable iff (!arst_n)
		(isCol && cmd == CMD_READ && readLatency == 3'h3 && !lower_byte_mask
		&& !upper_byte_mask) ##1 (readLatency == 3'h3 && !lower_byte_mask)[*2]
		|=> dataOutEnable[0])
		else $error("Latency three output missing");
	a_mask_read: assert property (@(posedge clock) disable iff (!arst_n)
		(lower_byte_mask && readLatency != 3'h1) |-> ##2 !dataOutEnable[0])
		else $error("Read mask latency wrong");
	a_col_each_clk: assert property (@(posedge clock) disable iff (!arst_n)
		isCol |=> beat == 10'h001)
		else $error("Column command not accepted");
	a_burst_one: assert property (@(posedge clock) disable iff (!arst_n)
		(isCol && burstCode == BL_CODE_1) |=> !burstActive)
		else $error("Length one burst continued");
	a_no_dpd: assert property (@(posedge clock) disable iff (!arst_n)
		!DEEP_PD_ENABLE |-> !deep_power_down)
		else $error("Deep power down without option");

	c_read: cover property (@(posedge clock) disable iff (!arst_n)
		isCol && cmd == CMD_READ ##3 dataOutEnable != 2'h0);
	c_write_burst: cover property (@(posedge clock) disable iff (!arst_n)
		isCol && cmd == CMD_WRITE ##1 burstActive);
	c_stop: cover property (@(posedge clock) disable iff (!arst_n)
		burstActive ##1 isCut);
	c_interleave: cover property (@(posedge clock) disable iff (!arst_n)
		interleave && burstActive);

endmodule
`default_nettype wire

// ---- core/msd_pkg.sv ----
// Purpose: Shared constants for the mobile SDRAM command and burst core.
// Assumes: Single 10 MHz system clock.
// Notes:   Mode field positions follow the address-key layout.
package msd_pkg;

	// -----------------------------------------------------------------
	// Geometry
	// -----------------------------------------------------------------
	localparam int DATA_W  = 16;
	localparam int ADDR_W  = 12;
	localparam int BANK_W  = 2;
	localparam int COL_W   = 9;

	// -----------------------------------------------------------------
	// Mode field positions and reset values
	// -----------------------------------------------------------------
	localparam int BL_LSB   = 0;
	localparam int BT_BIT   = 3;
	localparam int CL_LSB   = 4;
	localparam int WBL_BIT  = 9;
	localparam logic [2:0] BL_RESET = 3'h0;
	localparam logic [2:0] CL_RESET = 3'h3;
	localparam logic       BT_RESET = 1'b0;

	// Burst length codes
	localparam logic [2:0] BL_CODE_1    = 3'h0;
	localparam logic [2:0] BL_CODE_2    = 3'h1;
	localparam logic [2:0] BL_CODE_4    = 3'h2;
	localparam logic [2:0] BL_CODE_8    = 3'h3;
	localparam logic [2:0] BL_CODE_PAGE = 3'h7;

	// Bank select values for the normal and extended mode programs
	localparam logic [1:0] MODE_SEL_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SEL_EXT    = 2'h2;

	// Read mask latency in clocks
	localparam int READ_MASK_LAT = 2;

	// -----------------------------------------------------------------
	// Commands as {rasN, casN, weN}
	// -----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		CMD_MODE      = 3'b000,
		CMD_REFRESH   = 3'b001,
		CMD_PRECHARGE = 3'b010,
		CMD_ACTIVATE  = 3'b011,
		CMD_WRITE     = 3'b100,
		CMD_READ      = 3'b101,
		CMD_STOP      = 3'b110,
		CMD_NOP       = 3'b111
	} msd_cmd_t;

endpackage

// ---- core/msd_burst_seq.sv ----
// Purpose: Column offset generator for one burst step.
// Assumes: Burst type and length already decoded.
// Notes:   Pure combinational; wrap is inside the burst window.
`timescale 1ns/10ps
`default_nettype none

module msd_burst_seq
	import msd_pkg::*;
(
	input  wire logic [COL_W-1:0] startCol,
	input  wire logic [COL_W-1:0] step,
	input  wire logic [COL_W-1:0] wrapMask,
	input  wire logic             interleave,
	output logic      [COL_W-1:0] column
);
	import msd_pkg::*;

	logic [COL_W-1:0] seqLow;

	always_comb
	begin
		seqLow = (startCol + step) & wrapMask;
		if (interleave)
			column = (startCol & ~wrapMask) | ((startCol ^ step) & wrapMask);
		else
			column = (startCol & ~wrapMask) | seqLow;
	end

endmodule
`default_nettype wire

// ---- verif/msd_ctl_model.sv ----
// Purpose: Controller model that drives the command, address and data pins.
// Assumes: The bench calls issue once per cycle; pins move on the falling edge.
// Notes:   Idle address and data lines toggle so stale values are never seen.
`timescale 1ns/10ps
`default_nettype none

module msd_ctl_model
	import msd_pkg::*;
(
	input  wire logic              clock,
	output logic                   clockEnable,
	output logic                   chipSelect_n,
	output logic                   rowStrobe_n,
	output logic                   colStrobe_n,
	output logic                   writeEnable_n,
	output logic      [BANK_W-1:0] bank,
	output logic      [ADDR_W-1:0] addr,
	output logic                   lowerMask,
	output logic                   upperMask,
	output logic      [DATA_W-1:0] dataIn
);
	initial
	begin
		clockEnable = 1'b1;
		chipSelect_n = 1'b1;
		{rowStrobe_n, colStrobe_n, writeEnable_n} = CMD_NOP;
		bank = '0;
		addr = '0;
		{upperMask, lowerMask} = 2'b00;
		dataIn = 16'h0000;
	end

	// Clock is 10 MHz, slow enough for a read latency of one
	// No activate, refresh or self refresh is issued and runs stay far below 64 ms,
	// so row, recovery and refresh spacing hold trivially
	// Single write words may follow each other on consecutive clocks, with no idle clock between them
	task automatic issue(input msd_cmd_t c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [1:0] m, input logic cs);
		@(negedge clock);
		chipSelect_n <= cs;
		{rowStrobe_n, colStrobe_n, writeEnable_n} <= c;
		bank <= b;
		addr <= (c == CMD_NOP) ? ~addr : a;
		dataIn <= (c == CMD_NOP) ? ~dataIn : d;
		{upperMask, lowerMask} <= m;
	endtask
endmodule

`default_nettype wire

// ---- verif/tb_msd_core.sv ----
// Purpose: Self-checking bench for the SDRAM command and burst core.
// Assumes: Memory model keeps the low four column bits.
// Notes:   Stepped latencies and lengths; random burst types, bursts and masks from a fixed seed.
`timescale 1ns/10ps
`default_nettype none

module tb_msd_core;
	import msd_pkg::*;
	logic              clock = 1'b0;
	logic              arst_n = 1'b0;
	logic              clockEnable, chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic              lowerMask, upperMask;
	logic [DATA_W-1:0] dataIn, dataOut;
	logic [1:0]        dataOutEnable;
	logic [2:0]        readLatency;
	logic              deep_power_down;
	logic [15:0]       expMem [4][16];
	logic [2:0]        blCodes [5] = '{BL_CODE_1, BL_CODE_2, BL_CODE_4, BL_CODE_8, BL_CODE_PAGE};
	logic [2:0]        lat, bl;
	logic              bt;
	int                errCount = 0;
	int                checked = 0;
	int                seed = 68;
	int                it;

	always #50 clock = ~clock;

	msd_ctl_model ctl (.clock(clock), .clockEnable(clockEnable), .chipSelect_n(chipSelect_n),
		.rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
		.bank(bank), .addr(addr), .lowerMask(lowerMask), .upperMask(upperMask), .dataIn(dataIn));

	msd_core #(.MEM_COLS(16), .DEEP_PD_ENABLE(1'b0)) DUT (.clock(clock), .arst_n(arst_n),
		.clockEnable(clockEnable), .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n),
		.colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n), .bank(bank), .addr(addr),
		.lower_byte_mask(lowerMask), .upper_byte_mask(upperMask), .dataIn(dataIn),
		.dataOut(dataOut), .dataOutEnable(dataOutEnable), .readLatency(readLatency),
		.deep_power_down(deep_power_down));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic close_out();
		if (errCount == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			errCount++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask

	function automatic logic [COL_W-1:0] colOf(input logic [COL_W-1:0] s, input int i,
		input logic [2:0] b, input logic t);
		logic [COL_W-1:0] m;
		m = (b == BL_CODE_PAGE) ? '1 : COL_W'((1 << b) - 1);
		return t ? ((s & ~m) | ((s ^ COL_W'(i)) & m)) : ((s & ~m) | ((s + COL_W'(i)) & m));
	endfunction

	// Two idle clocks after every mode program
	task automatic prog(input logic [2:0] l, input logic [2:0] b, input logic t,
		input logic w, input logic [1:0] sel);
		ctl.issue(CMD_MODE, sel, {2'b00, w, 2'b00, l, t, b}, 16'h0000, 2'b00, 1'b0);
		ctl.issue(CMD_NOP, '0, '0, '0, 2'b00, 1'b0);
		ctl.issue(CMD_NOP, '0, '0, '0, 2'b00, 1'b0);
	endtask

	task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic [15:0] d,
		input logic [1:0] m);
		ctl.issue(CMD_WRITE, b, ADDR_W'(c), d, m, 1'b0);
		if (!m[0])
			expMem[b][c][7:0] = d[7:0];
		if (!m[1])
			expMem[b][c][15:8] = d[15:8];
	endtask

	// Read with optional stop at step s and a byte mask m at step mk
	task automatic rd(input logic [1:0] b, input logic [COL_W-1:0] c, input int l,
		input logic [2:0] bb, input logic t, input int s, input int mk, input logic [1:0] m);
		int n;
		logic [1:0] e;
		logic [COL_W-1:0] col;
		n = (s > 0) ? s : ((bb == BL_CODE_PAGE) ? 1 : (1 << bb));
		ctl.issue(CMD_READ, b, ADDR_W'(c), 16'h0000, 2'b00, 1'b0);
		for (int k = 1; k <= l + n; k++)
		begin
			ctl.issue((k == s) ? CMD_STOP : CMD_NOP, b, '0, '0, (k == mk) ? m : 2'b00, 1'b0);
			e = (k >= l && k < l + n) ? 2'b11 : 2'b00;
			if (k == mk + 2)
				e = e & ~m;
			chk("dataOutEnable", 16'(e), 16'(dataOutEnable));
			col = colOf(c, k - l, bb, t);
			if (e == 2'b11)
				chk("dataOut", expMem[b][col[3:0]], dataOut);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		#500000;
		errCount++;
		close_out();
	end

	initial
	begin
		repeat (12) @(negedge clock);
		arst_n = 1'b1;
		chk("readLatency", 16'(CL_RESET), 16'(readLatency));
		chk("dataOutEnable", 16'h0000, 16'(dataOutEnable));
		prog(3'h3, BL_CODE_1, 1'b0, 1'b0, MODE_SEL_NORMAL);
		for (it = 0; it < 64; it++)
			wr(2'(it / 16), 4'(it), 16'($random(seed)), 2'b00);
		for (it = 0; it < 16; it++)
			wr(2'($random(seed)), 4'($random(seed)), 16'($random(seed)), 2'($random(seed)));
		for (it = 0; it < 25; it++)
		begin
			lat = 3'(1 + it % 3);
			bl = blCodes[it % 5];
			bt = (bl == BL_CODE_PAGE) ? 1'b0 : 1'($random(seed));
			prog(lat, bl, bt, 1'b0, MODE_SEL_NORMAL);
			chk("readLatency", 16'(lat), 16'(readLatency));
			rd(2'($random(seed)), 9'($random(seed)), lat, bl, bt,
				(bl == BL_CODE_PAGE) ? 1 + it % 6 : 0, 1 + it % 4, 2'($random(seed)));
		end
		prog(3'h1, BL_CODE_1, 1'b0, 1'b0, MODE_SEL_EXT);
		chk("readLatency", 16'(lat), 16'(readLatency));
		ctl.issue(CMD_READ, 2'h0, 12'h000, 16'h0000, 2'b00, 1'b1);
		for (it = 0; it < 5; it++)
		begin
			ctl.issue(CMD_NOP, '0, '0, '0, 2'b00, 1'b0);
			chk("dataOutEnable", 16'h0000, 16'(dataOutEnable));
		end
		prog(3'h2, BL_CODE_4, 1'b0, 1'b1, MODE_SEL_NORMAL);
		wr(2'h1, 4'h4, 16'($random(seed)), 2'b00);
		// Idle clocks let a wrongly started write burst reach the next columns
		repeat (3) ctl.issue(CMD_NOP, 2'h1, '0, '0, 2'b00, 1'b0);
		rd(2'h1, 9'h004, 2, BL_CODE_4, 1'b0, 0, 0, 2'b00);
		chk("deep_power_down", 16'h0000, 16'(deep_power_down));
		close_out();
	end
endmodule

`default_nettype wire
